// ===== hw/link_event_pkg.sv
// constants and carrier types for the link event status unit
// assumes a single 25 MHz clock domain with a synchronous reset
package link_event_pkg;
	localparam int addr_w = 12;
	localparam logic [11:0] link_control_off = 12'h0040;
	localparam logic [11:0] link_events_off = 12'h0044;
	localparam logic [11:0] link_event_enables_off = 12'h0048;
	localparam logic [11:0] system_irq_status_off = 12'h004c;
	// link control fields
	localparam int cycle_master_bit = 11;
	localparam int overrun_inhibit_bit = 10;
	localparam int fault_clear_bit = 8;
	localparam int fault_code_lsb = 4;
	localparam int auto_master_bit = 3;
	// event flag positions and width
	localparam int event_lsb = 9;
	localparam int event_w = 13;
	localparam int header_crc_bit = 21;
	localparam int self_id_bit = 20;
	localparam int iso_arb_bit = 19;
	localparam int overrun_bit = 18;
	localparam int cycle_missing_bit = 17;
	localparam int cycle_arb_bit = 16;
	localparam int phy_event_bit = 10;
	localparam int phy_reg_bit = 9;
	// implemented event bits, the rest read zero; plain read-write bits of link control
	localparam logic [31:0] events_mask = 32'h003f_0600;
	localparam logic [31:0] control_rw_mask = 32'h0000_0408;
	// reset values
	localparam logic [31:0] control_reset = 32'h0000_0000;
	localparam logic [2:0] fault_none = 3'h0;
	typedef enum logic [2:0] {
		fault_no_error, fault_not_child, fault_bad_phy_id, fault_phase,
		fault_multi_gap, fault_large_gap, fault_id_in_packet, fault_not_inverse
	} self_id_fault_t;
	// hardware event strobes, one cycle each
	typedef struct packed {
		logic header_crc_fault;
		logic self_id_fault;
		logic iso_arbitration_loss;
		logic cycle_overrun;
		logic cycle_timer_wrap;
		logic cycle_start_seen;
		logic cycle_arbitration_loss;
		logic phy_irq;
		logic phy_register_arrival;
		logic became_root;
		logic [2:0] self_id_code;
	} link_hw_events_t;
	// register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage : link_event_pkg

// ===== hw/event_flag.sv
// one sticky event flag with write-one-to-clear
// assumes set and clear come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module event_flag (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// set and clear
	input wire logic set_evt,
	input wire logic clear_one,
	// state
	output logic flag_q
);
	logic flag_d;
	// set wins so a same-cycle event is never lost
	always_comb begin
		flag_d = flag_q;
		if (clear_one) flag_d = 1'b0;
		if (set_evt) flag_d = 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) flag_q <= 1'b0;
		else flag_q <= flag_d;
	end
endmodule : event_flag
`default_nettype wire

// ===== hw/link_event_status_unit.sv
// link control, link event flags, enables and link irq
// assumes event strobes are synchronous one-cycle pulses on sys_clk
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module link_event_status_unit (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register port
	input wire link_event_pkg::reg_req_t req,
	output logic [31:0] rdata_q,
	// hardware events
	input wire link_event_pkg::link_hw_events_t hw,
	// status outputs
	output logic cycle_master_enable_q,
	output logic system_link_irq_q
);
	logic wr_control, wr_events, wr_enables, wr_sysirq;
	logic [31:0] wd;
	logic root_auto_cycle_master_q, root_auto_cycle_master_d;
	logic overrun_clear_inhibit_q, overrun_clear_inhibit_d;
	logic cycle_master_enable_d;
	logic [2:0] self_id_fault_code_q, self_id_fault_code_d;
	logic [31:0] link_event_enables_q, link_event_enables_d;
	logic [31:0] set_vec;
	logic wrap_once_q, wrap_once_d;
	logic [31:0] link_events;
	logic system_link_irq_d;
	logic [31:0] rdata_d;

	// address decode, one aligned word per register
	assign wd = req.wdata;
	assign wr_control = req.wr && (req.addr == link_event_pkg::link_control_off);
	assign wr_events = req.wr && (req.addr == link_event_pkg::link_events_off);
	assign wr_enables = req.wr && (req.addr == link_event_pkg::link_event_enables_off);
	assign wr_sysirq = req.wr && (req.addr == link_event_pkg::system_irq_status_off);

	// hardware set vector in register bit positions
	always_comb begin
		set_vec = 32'h0000_0000;
		set_vec[link_event_pkg::header_crc_bit] = hw.header_crc_fault;
		set_vec[link_event_pkg::self_id_bit] = hw.self_id_fault;
		set_vec[link_event_pkg::iso_arb_bit] = hw.iso_arbitration_loss;
		set_vec[link_event_pkg::overrun_bit] = hw.cycle_overrun;
		// loss only counted when another node is master
		set_vec[link_event_pkg::cycle_missing_bit] = hw.cycle_timer_wrap && !hw.cycle_start_seen
			&& !cycle_master_enable_q && wrap_once_q;
		set_vec[link_event_pkg::cycle_arb_bit] = hw.cycle_arbitration_loss;
		set_vec[link_event_pkg::phy_event_bit] = hw.phy_irq;
		set_vec[link_event_pkg::phy_reg_bit] = hw.phy_register_arrival;
	end

	// wrap tracker: second wrap without cycle start flags the loss
	// the tracker stays armed after a loss, so each further silent wrap flags again
	always_comb begin
		wrap_once_d = wrap_once_q;
		if (hw.cycle_start_seen || cycle_master_enable_q) wrap_once_d = 1'b0;
		else if (hw.cycle_timer_wrap) wrap_once_d = 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) wrap_once_q <= 1'b0;
		else wrap_once_q <= wrap_once_d;
	end

	// sticky flags, only implemented bits exist
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (link_event_pkg::events_mask[gi]) begin : g_on
				event_flag u_flag (
					.sys_clk(sys_clk),
					.srst(srst),
					.set_evt(set_vec[gi]),
					.clear_one(wr_events && wd[gi]),
					.flag_q(link_events[gi])
				);
			end else begin : g_off
				assign link_events[gi] = 1'b0;
			end
		end
	endgenerate

	// link control and enables
	always_comb begin
		root_auto_cycle_master_d = root_auto_cycle_master_q;
		overrun_clear_inhibit_d = overrun_clear_inhibit_q;
		cycle_master_enable_d = cycle_master_enable_q;
		self_id_fault_code_d = self_id_fault_code_q;
		link_event_enables_d = link_event_enables_q;
		if (wr_control) begin
			root_auto_cycle_master_d = wd[link_event_pkg::auto_master_bit];
			overrun_clear_inhibit_d = wd[link_event_pkg::overrun_inhibit_bit];
			// auto mode locks out software writes of the cycle master bit
			if (!root_auto_cycle_master_q) cycle_master_enable_d = wd[link_event_pkg::cycle_master_bit];
			if (wd[link_event_pkg::fault_clear_bit]) self_id_fault_code_d = link_event_pkg::fault_none;
		end
		if (wr_enables) link_event_enables_d = wd & link_event_pkg::events_mask;
		// first fault only; a new fault beats a same-cycle clear only while no code is held
		if (hw.self_id_fault && self_id_fault_code_q == link_event_pkg::fault_none) begin
			self_id_fault_code_d = hw.self_id_code;
		end
		if (root_auto_cycle_master_q && hw.became_root) cycle_master_enable_d = 1'b1;
		// overrun wins over root promotion; inhibit keeps it
		if (hw.cycle_overrun && !overrun_clear_inhibit_q) cycle_master_enable_d = 1'b0;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			root_auto_cycle_master_q <= 1'b0;
			overrun_clear_inhibit_q <= 1'b0;
			cycle_master_enable_q <= 1'b0;
			self_id_fault_code_q <= link_event_pkg::fault_none;
			link_event_enables_q <= 32'h0000_0000;
		end else begin
			root_auto_cycle_master_q <= root_auto_cycle_master_d;
			overrun_clear_inhibit_q <= overrun_clear_inhibit_d;
			cycle_master_enable_q <= cycle_master_enable_d;
			self_id_fault_code_q <= self_id_fault_code_d;
			link_event_enables_q <= link_event_enables_d;
		end
	end

	// system link irq: sticky, set by enabled hardware set, write one clears
	always_comb begin
		system_link_irq_d = system_link_irq_q;
		if (wr_sysirq && wd[1]) system_link_irq_d = 1'b0;
		if (|(set_vec & link_event_enables_q)) system_link_irq_d = 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) system_link_irq_q <= 1'b0;
		else system_link_irq_q <= system_link_irq_d;
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (req.rd) begin
			unique case (req.addr)
				link_event_pkg::link_control_off: begin
					rdata_d[link_event_pkg::cycle_master_bit] = cycle_master_enable_q;
					rdata_d[link_event_pkg::overrun_inhibit_bit] = overrun_clear_inhibit_q;
					rdata_d[link_event_pkg::fault_code_lsb +: 3] = self_id_fault_code_q;
					rdata_d[link_event_pkg::auto_master_bit] = root_auto_cycle_master_q;
				end
				link_event_pkg::link_events_off: rdata_d = link_events;
				link_event_pkg::link_event_enables_off: rdata_d = link_event_enables_q;
				link_event_pkg::system_irq_status_off: rdata_d[1] = system_link_irq_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) rdata_q <= 32'h0000_0000;
		else rdata_q <= rdata_d;
	end

	// checks
	chk_overrun_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.cycle_overrun |=> link_events[link_event_pkg::overrun_bit])
		else $error("overrun flag not set");
	chk_overrun_master: assert property (@(posedge sys_clk) disable iff (srst)
		hw.cycle_overrun && !overrun_clear_inhibit_q |=> !cycle_master_enable_q)
		else $error("master not cleared on overrun");
	chk_inhibit_keeps: assert property (@(posedge sys_clk) disable iff (srst)
		hw.cycle_overrun && overrun_clear_inhibit_q && cycle_master_enable_q && !wr_control
		|=> cycle_master_enable_q)
		else $error("inhibit failed");
	chk_auto_root: assert property (@(posedge sys_clk) disable iff (srst)
		root_auto_cycle_master_q && hw.became_root && !hw.cycle_overrun |=> cycle_master_enable_q)
		else $error("auto master not set");
	chk_auto_lock: assert property (@(posedge sys_clk) disable iff (srst)
		root_auto_cycle_master_q && wr_control && !hw.became_root && !hw.cycle_overrun
		|=> $stable(cycle_master_enable_q))
		else $error("software changed master in auto mode");
	chk_first_fault: assert property (@(posedge sys_clk) disable iff (srst)
		self_id_fault_code_q != 3'h0 && !(wr_control && wd[8]) |=> $stable(self_id_fault_code_q))
		else $error("fault code overwritten");
	chk_code_clear: assert property (@(posedge sys_clk) disable iff (srst)
		wr_control && wd[8] && !hw.self_id_fault |=> self_id_fault_code_q == 3'h0)
		else $error("fault code not cleared");
	chk_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
		wr_events && wd[link_event_pkg::phy_event_bit] && hw.phy_irq
		|=> link_events[link_event_pkg::phy_event_bit])
		else $error("set lost to clear");
	chk_w1c_clear: assert property (@(posedge sys_clk) disable iff (srst)
		wr_events && wd[link_event_pkg::phy_reg_bit] && !hw.phy_register_arrival
		|=> !link_events[link_event_pkg::phy_reg_bit])
		else $error("write one did not clear");
	chk_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
		!system_link_irq_q && !(|(set_vec & link_event_enables_q)) |=> !system_link_irq_q)
		else $error("irq without enabled event");
	chk_irq_raise: assert property (@(posedge sys_clk) disable iff (srst)
		|(set_vec & link_event_enables_q) |=> system_link_irq_q)
		else $error("irq not raised");
	chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst)
		req.rd && req.addr == link_event_pkg::link_events_off |=> (rdata_q & ~link_event_pkg::events_mask) == 0)
		else $error("reserved bits read nonzero");
	// each flagged event strobe lands in its own flag one edge later; a wrap only when armed and not master
	chk_header_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.header_crc_fault |=> link_events[link_event_pkg::header_crc_bit])
		else $error("header crc flag not set");
	chk_self_id_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.self_id_fault |=> link_events[link_event_pkg::self_id_bit])
		else $error("self-id fault flag not set");
	chk_iso_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.iso_arbitration_loss |=> link_events[link_event_pkg::iso_arb_bit])
		else $error("iso arbitration flag not set");
	chk_loss_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.cycle_timer_wrap && !hw.cycle_start_seen && wrap_once_q && !cycle_master_enable_q
		|=> link_events[link_event_pkg::cycle_missing_bit])
		else $error("cycle loss flag not set");
	// a master node never reports a lost cycle start
	chk_loss_master: assert property (@(posedge sys_clk) disable iff (srst)
		cycle_master_enable_q && !link_events[link_event_pkg::cycle_missing_bit]
		|=> !link_events[link_event_pkg::cycle_missing_bit])
		else $error("cycle loss flagged while master");
	chk_cycle_arb_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.cycle_arbitration_loss |=> link_events[link_event_pkg::cycle_arb_bit])
		else $error("cycle arbitration flag not set");
	chk_phy_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.phy_irq |=> link_events[link_event_pkg::phy_event_bit])
		else $error("phy event flag not set");
	chk_phy_reg_flag: assert property (@(posedge sys_clk) disable iff (srst)
		hw.phy_register_arrival |=> link_events[link_event_pkg::phy_reg_bit])
		else $error("phy register flag not set");
	// control reads show only master, inhibit, fault code and auto
	chk_control_reserved: assert property (@(posedge sys_clk) disable iff (srst)
		req.rd && req.addr == link_event_pkg::link_control_off
		|=> (rdata_q & ~(link_event_pkg::control_rw_mask | (32'h0000_0001 << link_event_pkg::cycle_master_bit)
		| (32'h0000_0007 << link_event_pkg::fault_code_lsb))) == 32'h0000_0000)
		else $error("control reserved bits read nonzero");
	chk_enable_reserved: assert property (@(posedge sys_clk) disable iff (srst)
		(link_event_enables_q & ~link_event_pkg::events_mask) == 32'h0000_0000)
		else $error("reserved enable bit held");
	// read data stands only in the cycle after a read strobe
	chk_idle_rdata: assert property (@(posedge sys_clk) disable iff (srst)
		!req.rd |=> rdata_q == 32'h0000_0000)
		else $error("read data outside read cycle");
	cov_overrun: cover property (@(posedge sys_clk) disable iff (srst) hw.cycle_overrun && cycle_master_enable_q);
	cov_fault: cover property (@(posedge sys_clk) disable iff (srst)
		hw.self_id_fault && self_id_fault_code_q == link_event_pkg::fault_none);
	cov_root: cover property (@(posedge sys_clk) disable iff (srst) hw.became_root && root_auto_cycle_master_q);
	cov_irq: cover property (@(posedge sys_clk) disable iff (srst) $rose(system_link_irq_q));
	cov_loss: cover property (@(posedge sys_clk) disable iff (srst) set_vec[link_event_pkg::cycle_missing_bit]);
endmodule : link_event_status_unit
`default_nettype wire

// ===== verif/phy_event_model.sv
// phy side model: one-cycle event strobes into the link event unit
// assumes it shares sys_clk with the unit and is driven by bench tasks
`timescale 1ns/1ps
`default_nettype none
module phy_event_model (
	// clock
	input wire logic sys_clk,
	// strobes to the unit
	output var link_event_pkg::link_hw_events_t hw
);
	initial hw = '0;
	// idle gap then a one-cycle strobe; code drops with it so a stale code never looks valid
	task automatic send(input link_event_pkg::link_hw_events_t e, input int gap);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		hw <= e;
		@(posedge sys_clk);
		hw <= '0;
	endtask : send
endmodule : phy_event_model
`default_nettype wire

// ===== verif/link_event_status_unit_bench.sv
// self-checking bench for the link event status unit
// assumes the phy model drives the event strobes and the bench owns the register port
`timescale 1ns/1ps
`default_nettype none
module link_event_status_unit_bench;
	logic sys_clk;
	logic srst;
	link_event_pkg::reg_req_t req;
	logic [31:0] rdata_q;
	link_event_pkg::link_hw_events_t hw;
	logic cycle_master_enable_q;
	logic system_link_irq_q;
	int error_cnt;
	int n_tests;
	// event strobe positions in the carrier, and the flag each one sets
	localparam int sbit[7] = '{12, 11, 10, 9, 6, 5, 4};
	localparam int rbit[7] = '{21, 20, 19, 18, 16, 10, 9};
	localparam logic [11:0] ctl = 12'h0040;
	localparam logic [11:0] evt = 12'h0044;
	localparam logic [11:0] ena = 12'h0048;
	localparam logic [11:0] sys = 12'h004c;
	link_event_status_unit dut (.sys_clk(sys_clk), .srst(srst), .req(req), .rdata_q(rdata_q), .hw(hw),
		.cycle_master_enable_q(cycle_master_enable_q), .system_link_irq_q(system_link_irq_q));
	phy_event_model phy (.sys_clk(sys_clk), .hw(hw));
	always #20 sys_clk = ~sys_clk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
	endtask : wr
	// read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1 check(rdata_q, exp);
	endtask : rd
	task automatic pulse(input int idx, input logic [2:0] code, input int gap);
		link_event_pkg::link_hw_events_t e;
		e = '0;
		e[idx] = 1'b1;
		e.self_id_code = code;
		phy.send(e, gap);
	endtask : pulse
	// let registered outputs follow an event before looking
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic t_reset_map;
		check({cycle_master_enable_q, system_link_irq_q}, 2'b00);
		rd(ctl, 32'h0000_0000);
		rd(evt, 32'h0000_0000);
		wr(ctl, 32'hffff_fff7);
		rd(ctl, 32'h0000_0c00);
		wr(ctl, 32'h0000_0000);
		wr(ena, 32'hffff_ffff);
		rd(ena, 32'h003f_0600);
		wr(ena, 32'h0000_0000);
		wr(12'h0050, 32'hffff_ffff);
		rd(12'h0050, 32'h0000_0000);
		$display("done: reset_map");
	endtask : t_reset_map
	task automatic t_flags;
		for (int i = 0; i < 7; i++) begin
			pulse(sbit[i], (i == 1) ? 3'h1 : 3'h0, 0);
			rd(evt, 32'h1 << rbit[i]);
			wr(evt, 32'h0000_0000);
			rd(evt, 32'h1 << rbit[i]);
			wr(evt, 32'h1 << rbit[i]);
			rd(evt, 32'h0000_0000);
		end
		check(32'(system_link_irq_q), 32'h0);
		$display("done: flags");
	endtask : t_flags
	task automatic t_fault_code;
		for (int c = 1; c < 8; c++) begin
			wr(ctl, 32'h0000_0100);
			pulse(11, c[2:0], 0);
			pulse(11, (c == 7) ? 3'h1 : 3'h7, 1);
			rd(ctl, 32'(c) << 4);
		end
		wr(ctl, 32'h0000_0100);
		rd(ctl, 32'h0000_0000);
		wr(evt, 32'hffff_ffff);
		$display("done: fault_code");
	endtask : t_fault_code
	task automatic t_master;
		wr(ctl, 32'h0000_0008);
		pulse(3, 3'h0, 0);
		settle;
		check(32'(cycle_master_enable_q), 32'h1);
		wr(ctl, 32'h0000_0008);
		settle;
		check(32'(cycle_master_enable_q), 32'h1);
		pulse(9, 3'h0, 0);
		settle;
		check(32'(cycle_master_enable_q), 32'h0);
		rd(evt, 32'h0004_0000);
		wr(ctl, 32'h0000_0408);
		pulse(3, 3'h0, 0);
		pulse(9, 3'h0, 2);
		settle;
		check(32'(cycle_master_enable_q), 32'h1);
		// first write drops auto mode, only then can master be cleared
		wr(ctl, 32'h0000_0000);
		wr(ctl, 32'h0000_0000);
		settle;
		check(32'(cycle_master_enable_q), 32'h0);
		wr(evt, 32'hffff_ffff);
		$display("done: master");
	endtask : t_master
	task automatic t_cycle_loss;
		pulse(8, 3'h0, 0);
		pulse(8, 3'h0, 3);
		rd(evt, 32'h0002_0000);
		wr(evt, 32'h0002_0000);
		// tracker is still armed from the loss, a start disarms it
		pulse(7, 3'h0, 0);
		pulse(8, 3'h0, 0);
		pulse(7, 3'h0, 0);
		pulse(8, 3'h0, 0);
		rd(evt, 32'h0000_0000);
		wr(ctl, 32'h0000_0800);
		pulse(8, 3'h0, 0);
		pulse(8, 3'h0, 0);
		rd(evt, 32'h0000_0000);
		wr(ctl, 32'h0000_0000);
		$display("done: cycle_loss");
	endtask : t_cycle_loss
	task automatic t_irq;
		wr(ena, 32'h0000_0400);
		pulse(5, 3'h0, 0);
		settle;
		check(32'(system_link_irq_q), 32'h1);
		rd(sys, 32'h0000_0002);
		wr(evt, 32'h0000_0400);
		wr(sys, 32'h0000_0002);
		settle;
		check(32'(system_link_irq_q), 32'h0);
		// set and clear land on the same edge
		fork
			pulse(5, 3'h0, 0);
			wr(evt, 32'h0000_0400);
		join
		rd(evt, 32'h0000_0400);
		$display("done: irq");
	endtask : t_irq
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// a hang is cut short and counted
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		stop_test;
	end
	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		req = '0;
		error_cnt = 0;
		n_tests = 0;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset_map;
		t_flags;
		t_fault_code;
		t_master;
		t_cycle_loss;
		t_irq;
		stop_test;
	end
endmodule : link_event_status_unit_bench
`default_nettype wire
